// ===== src/hsc_cfg.svh
// constants for the hypervisor system control register
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH
// system coprocessor access encoding
`define HSC_OPC1 3'h4
`define HSC_OPC2 3'h0
`define HSC_CRN 4'h1
`define HSC_CRM 4'h0
// field positions
`define HSC_FI_BIT 21
`define HSC_WXN_BIT 19
`define HSC_BR_BIT 17
`define HSC_I_BIT 12
`define HSC_SED_BIT 8
`define HSC_ITD_BIT 7
`define HSC_BEN_BIT 5
`define HSC_C_BIT 2
`define HSC_A_BIT 1
`define HSC_M_BIT 0
// writable field mask and fixed-one bits (18, 16, 11, 4, 3)
`define HSC_RW_MASK 32'h002a11a7
`define HSC_RES1 32'h00050818
// reset value: defined fields 0, unknown fields taken as 0
`define HSC_RESET 32'h00000000
// if-then encoding checked against this low nibble
`define HSC_IT_MASK_OK 4'h8
`endif

// ===== src/hsc_ctrl.sv
// hypervisor system control register with its decoded controls
`timescale 1ns/1ps
`default_nettype none
`include "hsc_cfg.svh"
module hsc_ctrl #(
	parameter bit HAS_IT_DISABLE = 1'b1,
	parameter bit HAS_BARRIER_EN = 1'b1,
	parameter bit HAS_MIXED_ENDIAN = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// coprocessor move port
	input wire hsc_pkg::hsc_cop_req_t cop_req,
	input wire hsc_pkg::hsc_level_t cop_level,
	input wire logic hyp_trap_group1,
	output logic [31:0] cop_rdata,
	output logic cop_ack,
	output logic cop_trap,
	// memory access under check
	input wire logic acc_valid,
	input wire hsc_pkg::hsc_level_t acc_level,
	input wire logic acc_instr,
	input wire logic acc_write,
	input wire logic acc_exclusive,
	input wire logic acc_misaligned,
	input wire logic acc_multiple,
	// MPU attributes of the access
	input wire logic kern_mpu_normal,
	input wire logic hyp_mpu_normal,
	input wire logic hyp_mpu_hit,
	input wire logic hyp_mpu_writable,
	input wire logic hyp_mpu_xn,
	input wire logic kern_cacheable,
	// instruction under check
	input wire logic ins_valid,
	input wire logic ins_is_it,
	input wire logic ins_in_it,
	input wire logic ins_endianness_set_instr,
	input wire logic ins_barrier,
	input wire logic [15:0] ins_hw1,
	input wire logic [15:0] it_hw1,
	// access verdicts
	output logic acc_fault,
	output logic acc_align_fault,
	output logic acc_use_bg,
	output logic acc_xn,
	output logic acc_cacheable,
	output logic acc_interruptible,
	output logic acc_outer_shareable,
	// instruction verdict and controls
	output logic ins_undefined,
	output hsc_pkg::hsc_ctrl_t ctrl
);
	// ---------------------------------------------
	// register storage
	// ---------------------------------------------
	logic [31:0] control_reg;
	logic [31:0] control_next;
	logic [31:0] wmask;
	logic sel_hit;
	logic hyp_ok;
	logic [31:0] view;

	// which fields this build actually implements
	always_comb begin
		wmask = `HSC_RW_MASK;
		if (!HAS_IT_DISABLE) wmask[`HSC_ITD_BIT] = 1'b0;
		if (!HAS_BARRIER_EN) wmask[`HSC_BEN_BIT] = 1'b0;
		if (!HAS_MIXED_ENDIAN) wmask[`HSC_SED_BIT] = 1'b0;
	end

	// encoding decode of the coprocessor move
	assign sel_hit = cop_req.valid && (cop_req.opc1 == `HSC_OPC1) && (cop_req.opc2 == `HSC_OPC2)
		&& (cop_req.crn == `HSC_CRN) && (cop_req.crm == `HSC_CRM);
	// only hypervisor, or kernel without trap, may reach the register
	assign hyp_ok = (cop_level == hsc_pkg::HSC_HYP)
		|| ((cop_level == hsc_pkg::HSC_KERNEL) && !hyp_trap_group1);

	// next value merges writable bits only
	assign control_next = (control_reg & ~wmask) | (cop_req.wdata & wmask);

	// register write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			control_reg <= `HSC_RESET;
		end else if (sel_hit && hyp_ok && cop_req.write) begin
			control_reg <= control_next;
		end
	end

	// read view with fixed bits applied
	always_comb begin
		view = (control_reg & wmask) | `HSC_RES1;
		if (!HAS_BARRIER_EN) view[`HSC_BEN_BIT] = 1'b1;
		if (!HAS_MIXED_ENDIAN) view[`HSC_SED_BIT] = 1'b1;
	end

	// decoded controls from the read view
	always_comb begin
		ctrl.fast_interrupt_cfg = view[`HSC_FI_BIT];
		ctrl.write_implies_nx = view[`HSC_WXN_BIT];
		ctrl.background_region_en = view[`HSC_BR_BIT];
		ctrl.instr_cache_en = view[`HSC_I_BIT];
		ctrl.endianness_set_instr_disable = view[`HSC_SED_BIT];
		ctrl.it_disable = view[`HSC_ITD_BIT];
		ctrl.legacy_barrier_en = view[`HSC_BEN_BIT];
		ctrl.data_cache_en = view[`HSC_C_BIT];
		ctrl.align_check_en = view[`HSC_A_BIT];
		ctrl.mpu_enable = view[`HSC_M_BIT];
	end

	// ---------------------------------------------
	// coprocessor answer
	// ---------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cop_ack <= 1'b0;
			cop_trap <= 1'b0;
			cop_rdata <= 32'h00000000;
		end else begin
			cop_ack <= sel_hit && hyp_ok;
			cop_trap <= sel_hit && (cop_level == hsc_pkg::HSC_KERNEL) && hyp_trap_group1;
			cop_rdata <= (sel_hit && hyp_ok && !cop_req.write) ? view : 32'h00000000;
		end
	end

	// ---------------------------------------------
	// access checks
	// ---------------------------------------------
	logic is_hyp;
	logic normal_mem;
	logic align_f;
	logic miss_f;
	logic xn_v;
	logic cache_v;
	assign is_hyp = (acc_level == hsc_pkg::HSC_HYP);

	// normal-memory attribute by level
	assign normal_mem = is_hyp ? hyp_mpu_normal : (kern_mpu_normal && hyp_mpu_normal);
	// alignment: exclusives always, others by enable at hypervisor level
	assign align_f = acc_misaligned && (acc_exclusive
		|| (is_hyp && ctrl.align_check_en));
	// region miss faults unless background region is on
	assign miss_f = is_hyp && ctrl.mpu_enable && !hyp_mpu_hit && !ctrl.background_region_en;
	// execute-never including write-implies-nx
	assign xn_v = is_hyp && acc_instr && ctrl.mpu_enable
		&& (hyp_mpu_xn || (ctrl.write_implies_nx && hyp_mpu_writable));

	// cacheability per level and access kind
	always_comb begin
		if (!is_hyp) begin
			cache_v = kern_cacheable;
		end else if (acc_instr) begin
			cache_v = ctrl.instr_cache_en && (normal_mem || !ctrl.mpu_enable);
		end else begin
			cache_v = ctrl.data_cache_en && normal_mem;
		end
	end

	// access verdict registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_fault <= 1'b0;
			acc_align_fault <= 1'b0;
			acc_use_bg <= 1'b0;
			acc_xn <= 1'b0;
			acc_cacheable <= 1'b0;
			acc_interruptible <= 1'b0;
			acc_outer_shareable <= 1'b0;
		end else begin
			acc_fault <= acc_valid && (miss_f || align_f || (xn_v && !acc_write));
			acc_align_fault <= acc_valid && align_f;
			acc_use_bg <= acc_valid && is_hyp && ctrl.mpu_enable && !hyp_mpu_hit
				&& ctrl.background_region_en;
			acc_xn <= acc_valid && xn_v;
			acc_cacheable <= acc_valid && cache_v;
			// base register restore is the pipeline's job on this flag
			acc_interruptible <= acc_valid && acc_multiple && normal_mem
				&& ctrl.fast_interrupt_cfg;
			acc_outer_shareable <= acc_valid && is_hyp && acc_instr && !ctrl.mpu_enable;
		end
	end

	// ---------------------------------------------
	// instruction checks
	// ---------------------------------------------
	logic it_bad;
	logic next_bad;
	logic undef_v;

	hsc_it_check u_it (
		.it_hw1(it_hw1),
		.next_hw1(ins_hw1),
		.it_bad(it_bad),
		.next_bad(next_bad)
	);

	// the pipeline says which half is the follower; condition is ignored
	always_comb begin
		undef_v = 1'b0;
		if (ins_endianness_set_instr && ctrl.endianness_set_instr_disable) undef_v = 1'b1;
		if (ins_barrier && !ctrl.legacy_barrier_en) undef_v = 1'b1;
		if (ins_is_it && ctrl.it_disable && it_bad) undef_v = 1'b1;
		if (ins_in_it && ctrl.it_disable && next_bad) undef_v = 1'b1;
	end

	// instruction verdict register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ins_undefined <= 1'b0;
		end else begin
			ins_undefined <= ins_valid && (acc_level == hsc_pkg::HSC_HYP) && undef_v;
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	fixed_bits_a: assert property (@(posedge clk) disable iff (!resetn)
		cop_ack && !$past(cop_req.write) |-> (cop_rdata & 32'h0010e640) == 32'h0
		&& (cop_rdata & `HSC_RES1) == `HSC_RES1)
		else $error("fixed bits wrong");
	trap_kernel_a: assert property (@(posedge clk) disable iff (!resetn)
		sel_hit && cop_level == hsc_pkg::HSC_KERNEL && hyp_trap_group1 |=> cop_trap && !cop_ack)
		else $error("kernel access not trapped");
	write_take_a: assert property (@(posedge clk) disable iff (!resetn)
		sel_hit && hyp_ok && cop_req.write |=> control_reg[`HSC_M_BIT] == $past(cop_req.wdata[0]))
		else $error("mpu enable not written");
	align_excl_a: assert property (@(posedge clk) disable iff (!resetn)
		acc_valid && acc_misaligned && acc_exclusive |=> acc_align_fault)
		else $error("exclusive alignment missed");
	align_off_a: assert property (@(posedge clk) disable iff (!resetn)
		acc_valid && !acc_exclusive && !ctrl.align_check_en |=> !acc_align_fault)
		else $error("alignment fault while disabled");
	bg_miss_a: assert property (@(posedge clk) disable iff (!resetn)
		acc_valid && is_hyp && ctrl.mpu_enable && !hyp_mpu_hit |=> acc_use_bg == $past(ctrl.background_region_en)
		&& (acc_fault || acc_use_bg))
		else $error("background choice wrong");
	kern_cache_a: assert property (@(posedge clk) disable iff (!resetn)
		acc_valid && !is_hyp |=> acc_cacheable == $past(kern_cacheable))
		else $error("kernel cacheability disturbed");
	wxn_force_a: assert property (@(posedge clk) disable iff (!resetn)
		acc_valid && is_hyp && acc_instr && ctrl.mpu_enable && ctrl.write_implies_nx
		&& hyp_mpu_writable |=> acc_xn)
		else $error("writable region not execute-never");
	endianness_set_instr_a: assert property (@(posedge clk) disable iff (!resetn)
		ins_valid && is_hyp && ins_endianness_set_instr && ctrl.endianness_set_instr_disable |=> ins_undefined)
		else $error("endianness set not refused");
	fi_a: assert property (@(posedge clk) disable iff (!resetn)
		acc_valid && !ctrl.fast_interrupt_cfg |=> !acc_interruptible)
		else $error("interruptible without fast interrupt");
	reset_val_a: assert property (@(posedge clk)
		!resetn |=> !ctrl.mpu_enable || $past(resetn))
		else $error("mpu enable not cleared by reset");
endmodule
`default_nettype wire

// ===== src/hsc_it_check.sv
// decoder for if-then blocks disabled by it_disable
`timescale 1ns/1ps
`default_nettype none
`include "hsc_cfg.svh"
module hsc_it_check (
	// instruction halfwords
	input wire logic [15:0] it_hw1,
	input wire logic [15:0] next_hw1,
	// results
	output logic it_bad,
	output logic next_bad
);
	// it encodings other than the single-slot mask form
	assign it_bad = (it_hw1[3:0] != `HSC_IT_MASK_OK);
	// follower patterns that are refused inside a block
	always_comb begin
		next_bad = 1'b0;
		if (next_hw1[15:14] == 2'b11) next_bad = 1'b1;
		else if (next_hw1[15:12] == 4'hb) next_bad = 1'b1;
		else if (next_hw1[15:11] == 5'h14) next_bad = 1'b1;
		else if (next_hw1[15:11] == 5'h09) next_bad = 1'b1;
		else if ((next_hw1[15:12] == 4'h4) && next_hw1[10] && (next_hw1[6:3] == 4'hf))
			next_bad = 1'b1;
		else if ((next_hw1[15:10] == 6'h11) && next_hw1[7] && (next_hw1[2:0] == 3'h7))
			next_bad = 1'b1;
	end
endmodule
`default_nettype wire

// ===== src/hsc_pkg.sv
// types for the hypervisor system control register
package hsc_pkg;
	// privilege level of an access
	typedef enum logic [2:0] {
		HSC_USER = 3'b001,
		HSC_KERNEL = 3'b010,
		HSC_HYP = 3'b100
	} hsc_level_t;
	// coprocessor move request
	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] opc1;
		logic [2:0] opc2;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [31:0] wdata;
	} hsc_cop_req_t;
	// decoded controls
	typedef struct packed {
		logic fast_interrupt_cfg;
		logic write_implies_nx;
		logic background_region_en;
		logic instr_cache_en;
		logic endianness_set_instr_disable;
		logic it_disable;
		logic legacy_barrier_en;
		logic data_cache_en;
		logic align_check_en;
		logic mpu_enable;
	} hsc_ctrl_t;
endpackage

// ===== verification/tb_top.sv
// self-checking bench for the hypervisor system control register
`timescale 1ns/1ps
`default_nettype none
`include "hsc_cfg.svh"
module tb_top;
	// ------------------------------------------------------------
	// stimulus, observation and design
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic trap1 = 1'b0;
	logic [11:0] a = '0; // access flags, then mpu attributes
	logic [4:0] iv = '0; // valid, is_it, in_it, endianness_set_instr, barrier
	logic [15:0] hw = '0;
	logic [15:0] ith = '0;
	logic [31:0] r = `HSC_RES1; // expected register view
	logic [31:0] rdata;
	logic ack;
	logic trap;
	logic [6:0] v; // fault, align, bg, xn, cacheable, interruptible, outer
	logic undef;
	int bad_count = 0;
	int n_checks = 0;
	hsc_pkg::hsc_cop_req_t req = '0;
	hsc_pkg::hsc_level_t clv = hsc_pkg::HSC_HYP;
	hsc_pkg::hsc_level_t alv = hsc_pkg::HSC_HYP;
	hsc_pkg::hsc_ctrl_t ctrl;

	hsc_ctrl i_dut (
		.clk(clk), .resetn(resetn), .cop_req(req), .cop_level(clv),
		.hyp_trap_group1(trap1), .cop_rdata(rdata), .cop_ack(ack), .cop_trap(trap),
		.acc_valid(a[11]), .acc_level(alv), .acc_instr(a[10]), .acc_write(a[9]),
		.acc_exclusive(a[8]), .acc_misaligned(a[7]), .acc_multiple(a[6]),
		.kern_mpu_normal(a[5]), .hyp_mpu_normal(a[4]), .hyp_mpu_hit(a[3]),
		.hyp_mpu_writable(a[2]), .hyp_mpu_xn(a[1]), .kern_cacheable(a[0]),
		.ins_valid(iv[4]), .ins_is_it(iv[3]), .ins_in_it(iv[2]), .ins_endianness_set_instr(iv[1]),
		.ins_barrier(iv[0]), .ins_hw1(hw), .it_hw1(ith),
		.acc_fault(v[6]), .acc_align_fault(v[5]), .acc_use_bg(v[4]), .acc_xn(v[3]),
		.acc_cacheable(v[2]), .acc_interruptible(v[1]), .acc_outer_shareable(v[0]),
		.ins_undefined(undef), .ctrl(ctrl)
	);

	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end

	// ------------------------------------------------------------
	// checking helpers
	// ------------------------------------------------------------
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// follower halfwords refused inside an if-then block
	function automatic logic follow(input logic [15:0] h);
		return h[15:14] == 2'b11 || h[15:12] == 4'hb || h[15:11] == 5'h14
			|| h[15:11] == 5'h09 || (h[15:12] == 4'h4 && h[10] && h[6:3] == 4'hf)
			|| (h[15:10] == 6'h11 && h[7] && h[2:0] == 3'h7);
	endfunction

	// one coprocessor move; request stays up for back-to-back use
	task automatic cop(input logic wr, input logic [31:0] wd, input logic good);
		logic ok;
		logic tp;
		ok = good && (clv == hsc_pkg::HSC_HYP || (clv == hsc_pkg::HSC_KERNEL && !trap1));
		tp = good && clv == hsc_pkg::HSC_KERNEL && trap1;
		req.valid = 1'b1;
		req.write = wr;
		req.opc1 = `HSC_OPC1;
		req.opc2 = `HSC_OPC2;
		req.crn = `HSC_CRN;
		req.crm = good ? `HSC_CRM : 4'h1; // neighbouring register when wrong
		req.wdata = wd;
		@(negedge clk);
		chk(ack, ok);
		chk(trap, tp);
		chk(rdata, (ok && !wr) ? r : 32'h0);
		if (ok && wr) r = (wd & `HSC_RW_MASK) | `HSC_RES1;
		chk(ctrl, {r[21], r[19], r[17], r[12], r[8], r[7], r[5], r[2], r[1], r[0]});
	endtask

	// verdicts for the access and instruction driven one cycle ago
	task automatic look();
		logic h;
		logic m;
		logic b;
		h = alv == hsc_pkg::HSC_HYP;
		m = r[0];
		b = a[10] ? r[12] : r[2];
		if (a[11] && h) begin
			chk(v[5], a[7] & (a[8] | r[1]));
			chk(v[4], m & !a[3] & r[17]);
			if (m && !a[3] && !r[17]) chk(v[6], 1'b1);
			if (m && a[3]) chk(v[3], a[10] & (a[1] | (r[19] & a[2])));
			if (m && a[3] && !a[7]) chk(v[6], a[10] & !a[9] & (a[1] | (r[19] & a[2])));
			if (!b) chk(v[2], 1'b0);
			if (m && a[3] && a[4] && b) chk(v[2], 1'b1);
			if (m) chk(v[1], r[21] & a[6] & a[4]);
			if (!m && a[10]) begin
				chk(v[0], 1'b1);
				chk(v[2], r[12]);
			end
		end
		if (a[11] && !h) begin
			chk(v[2], a[0]);
			if (m) chk(v[1], r[21] & a[6] & a[5] & a[4]);
		end
		if (iv[4]) chk(undef, h & ((iv[1] & r[8]) | (iv[0] & !r[5])
			| (iv[3] & r[7] & (hw[3:0] != 4'h8)) | (iv[2] & r[7] & follow(hw))));
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] w;
		int k;
		w = $urandom(65184);
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		cop(1'b0, 32'h0, 1'b1);
		cop(1'b1, 32'hffffffff, 1'b1);
		cop(1'b0, 32'h0, 1'b1);
		cop(1'b1, 32'h0, 1'b0);
		cop(1'b0, 32'h0, 1'b0);
		clv = hsc_pkg::HSC_USER;
		cop(1'b1, 32'h0, 1'b1);
		clv = hsc_pkg::HSC_KERNEL;
		trap1 = 1'b1;
		cop(1'b1, 32'h0, 1'b1);
		trap1 = 1'b0;
		cop(1'b1, 32'h1, 1'b1);
		clv = hsc_pkg::HSC_HYP;
		cop(1'b0, 32'h0, 1'b1);
		req.valid = 1'b0;
		// random register contents with random accesses and instructions
		for (int n = 0; n < 600; n++) begin
			if (n % 25 == 0) begin
				clv = ($urandom % 2) ? hsc_pkg::HSC_HYP : hsc_pkg::HSC_KERNEL;
				trap1 = 1'($urandom);
				cop(1'b1, $urandom, 1'b1);
				req.valid = 1'b0;
			end
			k = $urandom % 4;
			a = 12'($urandom);
			hw = 16'($urandom);
			ith = (k == 3) ? hw : {~hw[15:4], 4'h8};
			iv = {1'($urandom), 4'h1 << k};
			alv = ($urandom % 3) ? hsc_pkg::HSC_HYP : hsc_pkg::HSC_KERNEL;
			@(negedge clk);
			look();
		end
		// second reset in mid-run
		resetn = 1'b0;
		@(negedge clk);
		r = `HSC_RES1;
		resetn = 1'b1;
		clv = hsc_pkg::HSC_HYP;
		cop(1'b0, 32'h0, 1'b1);
		req.valid = 1'b0;
		end_sim();
	end

	// cuts a hang short
	initial begin
		#1000000;
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
